/* File: wol_pkg.sv */
// package: register map, field positions and timing for the wake-on-lan receive block
package wol_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [8:0] IDX_CONFIG = 9'h134;
    localparam logic [8:0] IDX_STATUS = 9'h135;
    localparam logic [8:0] IDX_MATCH0 = 9'h136;
    localparam logic [8:0] IDX_MATCH1 = 9'h137;
    localparam logic [8:0] IDX_MATCH2 = 9'h138;
    localparam logic [8:0] IDX_PASS0 = 9'h139;
    localparam logic [8:0] IDX_PASS1 = 9'h13a;
    localparam logic [8:0] IDX_PASS2 = 9'h13b;
    localparam int ADDR_W = 11;
    // configuration fields
    localparam int B_CLEAR = 11;
    localparam int B_WIDTH_LO = 9;
    localparam int B_FORM = 8;
    localparam int B_ENH = 7;
    localparam int B_PASS_EN = 5;
    localparam int B_UCAST = 4;
    localparam int B_BCAST = 2;
    localparam int B_PATTERN = 1;
    localparam int B_MAGIC = 0;
    localparam logic [15:0] CONFIG_RESET = 16'h0004;
    localparam logic [15:0] CONFIG_WMASK = 16'h07b7;
    // status fields
    localparam int S_SFD = 7;
    localparam int S_CRC = 6;
    localparam int S_PFAIL = 5;
    localparam int S_UCAST = 4;
    localparam int S_BCAST = 2;
    localparam int S_PATTERN = 1;
    localparam int S_MAGIC = 0;
    // pulse widths in 125 MHz cycles, selected by the two-bit width field
    localparam int PULSE_W0 = 8;
    localparam int PULSE_W1 = 16;
    localparam int PULSE_W2 = 32;
    localparam int PULSE_W3 = 64;
    localparam int OUT_CLK_MHZ = 125;
    localparam int CLK_MHZ = 40;
    localparam int CNT_W = 7;
    typedef enum logic [1:0] {WOL_IDLE, WOL_PULSE, WOL_LEVEL} wol_state_t;
endpackage

/* File: wol_word_regs.sv */
// small memory of 16-bit words for match value and password, registered read
module wol_word_regs #(
    parameter int WORDS = 6
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire logic [2:0] rd_idx,
    output logic [15:0] rd_data,
    output logic [16*WORDS-1:0] all_words
);
    if (WORDS < 1 || WORDS > 8) begin : g_bad_words
        $error("wol_word_regs: WORDS out of range");
    end
    logic [15:0] mem [WORDS];
    genvar g;
    generate
        for (g = 0; g < WORDS; g++) begin : g_word
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    mem[g] <= 16'h0000;
                end else if (wr_en && wr_idx == 3'(g)) begin
                    mem[g] <= wr_data;
                end
            end
            assign all_words[16*g +: 16] = mem[g];
        end
    endgenerate
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 16'h0000;
        end else begin
            rd_data <= (32'(rd_idx) < WORDS) ? mem[rd_idx] : 16'h0000;
        end
    end
endmodule

/* File: wol_rx_wake.sv */
// wake-on-lan receive configuration, status and wake output shaping
// Functional notes
// (RULE1) a form bit in the configuration selects a held level or a timed pulse on the wake output.
// (RULE2) in pulse form the width is 8, 16, 32 or 64 cycles of 125 MHz per the two-bit width field.
// (RULE3) writing one to the clear bit drops a level-form output, the bit reads back zero, and it does nothing in pulse form.
// (RULE4) the enhanced-receive enable turns on wake detection, crc checking and the time-stamp indication.
// (RULE5) with the password enable set, a magic packet wakes only if its password matches the stored one.
// (RULE6) the unicast enable lets a valid unicast frame raise a wake event.
// (RULE7) the broadcast enable lets a valid broadcast frame raise a wake event and is set after reset.
// (RULE8) the pattern enable lets a pattern-matching frame raise a wake event.
// (RULE9) the magic enable lets a valid magic packet raise a wake event.
// (RULE10) each receive-status flag sets on its event, holds until read and is cleared by the read.
// (RULE11) the 48-bit magic password is three writable 16-bit words, bits 47:32 in the highest.
// (RULE12) a 48-bit match value in three words is compared with the destination address of frames.
// (RULE13) in level form the output rises on the first enabled event and holds until cleared.
// (RULE14) with the enhanced-receive enable low no wake event is made at all.
//
// Added by the designer: the Avalon-MM register port.
module wol_rx_wake
    import wol_pkg::*;
#(
    parameter int PASS_W = 48
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [wol_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic RX_FRAME_END,
    input wire logic RX_UNICAST,
    input wire logic RX_BROADCAST,
    input wire logic RX_PATTERN_HIT,
    input wire logic RX_MAGIC,
    input wire logic [47:0] RX_MAGIC_PASSWORD,
    input wire logic [47:0] RX_DEST_ADDR,
    input wire logic RX_CRC_BAD,
    input wire logic RX_SFD_BAD,
    output logic WAKE_OUT,
    output logic DEST_MATCH,
    output logic CRC_CHECK_EN,
    output logic STAMP_IND_EN
);
    import wol_pkg::*;

    // ****************************************
    // elaboration checks
    // ****************************************
    if (PASS_W != 48) begin : g_bad_pass
        $error("wol_rx_wake: PASS_W must be 48");
    end
    // the longest pulse must still fit the down-counter
    if ((PULSE_W3 * CLK_MHZ + OUT_CLK_MHZ - 1) / OUT_CLK_MHZ >= 2 ** CNT_W) begin : g_bad_cnt
        $error("wol_rx_wake: pulse counter too narrow");
    end

    // ****************************************
    // pulse timing
    // ****************************************
    // a 125 MHz cycle count becomes 40 MHz cycles, rounded up so no pulse is short
    function automatic logic [CNT_W-1:0] pulse_cycles(input logic [1:0] sel);
        int n;
        n = (sel == 2'h0) ? PULSE_W0 : (sel == 2'h1) ? PULSE_W1 :
            (sel == 2'h2) ? PULSE_W2 : PULSE_W3;
        n = (n * CLK_MHZ + OUT_CLK_MHZ - 1) / OUT_CLK_MHZ;
        return CNT_W'(n < 1 ? 1 : n);
    endfunction

    function automatic logic [2:0] word_of(input logic [8:0] idx);
        return 3'(idx - IDX_MATCH0);
    endfunction

    // ****************************************
    // bus slave
    // ****************************************
    logic [15:0] config_reg;
    logic [7:0] status_reg;
    logic ack;
    logic [8:0] idx;
    logic addr_ok;
    logic in_words;
    logic acc;
    logic wr_cfg;
    logic rd_sts;
    logic wr_words;
    logic [15:0] wdata16;
    logic [15:0] word_rd;
    logic [95:0] words;
    logic [47:0] match_value;
    logic [47:0] password;

    assign idx = AVS_ADDRESS[ADDR_W-1:2];
    assign addr_ok = AVS_ADDRESS[1:0] == 2'h0;
    assign in_words = idx >= IDX_MATCH0 && idx <= IDX_PASS2;
    // waitrequest is high until the one-cycle ack; the request is taken at the ack edge
    assign acc = (AVS_READ || AVS_WRITE) && ack;
    assign wdata16 = AVS_WRITEDATA[15:0];
    assign wr_cfg = acc && AVS_WRITE && addr_ok && idx == IDX_CONFIG;
    assign rd_sts = acc && AVS_READ && addr_ok && idx == IDX_STATUS;
    assign wr_words = acc && AVS_WRITE && addr_ok && in_words && AVS_BYTEENABLE[1:0] == 2'h3;
    assign match_value = words[47:0];
    assign password = words[95:48];

    // ****************************************
    // wait states
    // ****************************************
    // a word-store read waits one cycle more: the store's read register is only filled
    // at the first edge that sees the request, so its data reach the bus one edge later
    logic slow_rd;
    logic held;
    logic go;
    assign slow_rd = AVS_READ && addr_ok && in_words;
    assign go = (AVS_READ || AVS_WRITE) && !ack && (!slow_rd || held);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            held <= 1'b0;
        end else begin
            held <= slow_rd && !ack && !held;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ack <= 1'b0;
        end else begin
            ack <= go;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= !go;
        end
    end

    // RULE11 RULE12: both 48-bit values share one word store, lowest word first
    wol_word_regs #(.WORDS(6)) u_words (
        .clk(CLK),
        .nrst(NRST),
        .wr_en(wr_words),
        .wr_idx(word_of(idx)),
        .wr_data(wdata16),
        .rd_idx(word_of(idx)),
        .rd_data(word_rd),
        .all_words(words)
    );

    // read data are loaded at the edge that drops waitrequest and hold until the next read;
    // word reads take theirs from the store's read register, which was filled one edge earlier
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (AVS_READ && !ack && !slow_rd) begin
            if (!addr_ok) begin
                AVS_READDATA <= 32'h0000_0000;
            end else if (idx == IDX_CONFIG) begin
                AVS_READDATA <= {16'h0000, config_reg};
            end else if (idx == IDX_STATUS) begin
                AVS_READDATA <= {24'h000000, status_reg};
            end else begin
                AVS_READDATA <= 32'h0000_0000;
            end
        end else if (AVS_READ && held) begin
            AVS_READDATA <= {16'h0000, word_rd};
        end
    end

    // ****************************************
    // configuration
    // ****************************************
    logic [15:0] next_config;
    always_comb begin
        next_config = config_reg;
        next_config[B_CLEAR] = 1'b0; // RULE3
        if (wr_cfg) begin
            if (AVS_BYTEENABLE[0]) begin
                next_config[7:0] = wdata16[7:0] & CONFIG_WMASK[7:0];
            end
            if (AVS_BYTEENABLE[1]) begin
                next_config[15:8] = wdata16[15:8] & CONFIG_WMASK[15:8];
                next_config[B_CLEAR] = wdata16[B_CLEAR];
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            config_reg <= CONFIG_RESET; // RULE7
        end else begin
            config_reg <= next_config;
        end
    end

    logic enh;
    assign enh = config_reg[B_ENH];

    // ****************************************
    // frame classification
    // ****************************************
    logic pass_ok;
    logic magic_valid;
    logic pass_fail;
    logic wake_event;
    assign pass_ok = RX_MAGIC_PASSWORD == password;
    assign magic_valid = RX_MAGIC && (!config_reg[B_PASS_EN] || pass_ok); // RULE5
    assign pass_fail = RX_MAGIC && config_reg[B_PASS_EN] && !pass_ok; // RULE5
    assign wake_event = enh && RX_FRAME_END && ( // RULE4 RULE14
        (config_reg[B_UCAST] && RX_UNICAST) || // RULE6
        (config_reg[B_BCAST] && RX_BROADCAST) || // RULE7
        (config_reg[B_PATTERN] && RX_PATTERN_HIT) || // RULE8
        (config_reg[B_MAGIC] && magic_valid)); // RULE9

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            DEST_MATCH <= 1'b0;
        end else if (RX_FRAME_END) begin
            DEST_MATCH <= RX_DEST_ADDR == match_value; // RULE12
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            CRC_CHECK_EN <= 1'b0;
            STAMP_IND_EN <= 1'b0;
        end else begin
            CRC_CHECK_EN <= next_config[B_ENH]; // RULE4
            STAMP_IND_EN <= next_config[B_ENH]; // RULE4
        end
    end

    // ****************************************
    // status flags
    // ****************************************
    logic [7:0] sts_set;
    always_comb begin
        sts_set = 8'h00;
        if (enh && RX_FRAME_END) begin
            sts_set[S_MAGIC] = magic_valid;
            sts_set[S_PATTERN] = RX_PATTERN_HIT;
            sts_set[S_BCAST] = RX_BROADCAST;
            sts_set[S_UCAST] = RX_UNICAST;
            sts_set[S_PFAIL] = pass_fail;
            sts_set[S_CRC] = RX_CRC_BAD;
            sts_set[S_SFD] = RX_SFD_BAD;
        end
    end

    // a read clears only the flags it returned: one set after the data were captured,
    // or in the clearing cycle itself, stays for the next read
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            status_reg <= 8'h00;
        end else begin
            status_reg <= (rd_sts ? status_reg & ~AVS_READDATA[7:0] : status_reg) | sts_set; // RULE10
        end
    end

    // ****************************************
    // wake output
    // ****************************************
    wol_state_t state;
    logic [CNT_W-1:0] pulse_cnt;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state <= WOL_IDLE;
            pulse_cnt <= '0;
            WAKE_OUT <= 1'b0;
        end else begin
            unique case (state)
                WOL_IDLE: begin
                    if (wake_event && config_reg[B_FORM]) begin
                        state <= WOL_LEVEL; // RULE1 RULE13
                        WAKE_OUT <= 1'b1;
                    end else if (wake_event) begin
                        state <= WOL_PULSE; // RULE1
                        pulse_cnt <= pulse_cycles(config_reg[10:B_WIDTH_LO]) - 1'b1; // RULE2
                        WAKE_OUT <= 1'b1;
                    end
                end
                WOL_PULSE: begin
                    if (pulse_cnt == '0) begin
                        state <= WOL_IDLE;
                        WAKE_OUT <= 1'b0;
                    end else begin
                        pulse_cnt <= pulse_cnt - 1'b1; // RULE2
                    end
                end
                WOL_LEVEL: begin
                    // further events are ignored; only the clear bit releases it
                    if (config_reg[B_CLEAR] && config_reg[B_FORM]) begin
                        state <= WOL_IDLE; // RULE3 RULE13
                        WAKE_OUT <= 1'b0;
                    end
                end
                default: begin
                    state <= WOL_IDLE;
                    WAKE_OUT <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* File: wol_rx_wake_checker.sv */
// checker: concurrent assertions on the ports of the wake-on-lan receive block
module wol_rx_wake_checker
    import wol_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [wol_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic RX_FRAME_END,
    input wire logic RX_UNICAST,
    input wire logic RX_BROADCAST,
    input wire logic RX_PATTERN_HIT,
    input wire logic RX_MAGIC,
    input wire logic WAKE_OUT,
    input wire logic CRC_CHECK_EN,
    input wire logic STAMP_IND_EN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cfg;
    logic [6:0] hi;
    logic [6:0] plen;
    logic wr_cfg;
    logic ev;
    assign wr_cfg = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 11'h4d0;
    assign plen = 7'(((PULSE_W0 << cfg[10:9]) * CLK_MHZ + OUT_CLK_MHZ - 1) / OUT_CLK_MHZ);
    // magic with password is left out: the checker cannot see the stored password
    assign ev = RX_FRAME_END && cfg[B_ENH] && (RX_UNICAST && cfg[B_UCAST]
        || RX_BROADCAST && cfg[B_BCAST] || RX_PATTERN_HIT && cfg[B_PATTERN]
        || RX_MAGIC && cfg[B_MAGIC] && !cfg[B_PASS_EN]);
    // shadow assumes full-word writes; the self-clearing bit is never kept
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) cfg <= CONFIG_RESET;
        else if (wr_cfg) cfg <= AVS_WRITEDATA[15:0] & CONFIG_WMASK;
    end
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) hi <= 7'h00;
        else hi <= WAKE_OUT ? hi + 7'h01 : 7'h00;
    end
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    a_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |-> ##[1:2] !AVS_WAITREQUEST) else $error("waitrequest late");
    a_cfg_read: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 11'h4d0
        |-> AVS_READDATA == {16'h0000, cfg}) else $error("config readback wrong");
    a_side_outs: assert property (CRC_CHECK_EN == cfg[B_ENH] && STAMP_IND_EN == cfg[B_ENH])
        else $error("enhanced outputs wrong");
    a_quiet_off: assert property (RX_FRAME_END && !cfg[B_ENH] && !WAKE_OUT |=> !WAKE_OUT)
        else $error("wake while disabled");
    a_wake_rise: assert property (ev && !WAKE_OUT |=> WAKE_OUT)
        else $error("wake missing");
    a_pulse_len: assert property ($fell(WAKE_OUT) && !cfg[B_FORM] |-> hi == plen)
        else $error("pulse width wrong");
    a_level_hold: assert property (cfg[B_FORM] && WAKE_OUT && !wr_cfg && !$past(wr_cfg)
        && !$past(wr_cfg, 2) |=> WAKE_OUT) else $error("level dropped");
    a_level_clear: assert property (wr_cfg && AVS_WRITEDATA[B_CLEAR] && cfg[B_FORM]
        && AVS_WRITEDATA[B_FORM] |-> ##[1:3] !WAKE_OUT) else $error("level not cleared");
    c_pulse: cover property ($fell(WAKE_OUT) && !cfg[B_FORM]);
    c_event: cover property (ev);
    c_clear: cover property (wr_cfg && AVS_WRITEDATA[B_CLEAR]);
endmodule
bind wol_rx_wake wol_rx_wake_checker i_chk (.*);

/* File: wol_station.sv */
// model of the remote station delivering received-frame indications
module wol_station (
    input wire logic clk,
    output logic fe,
    output logic [7:0] k,
    output logic [47:0] pw,
    output logic [47:0] da
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        fe = 1'b0;
        k = 8'h00;
        pw = 48'h0;
        da = 48'h0;
    end
    // kind bits sit on the status flag positions; between frames the
    // qualifiers show the inverse of the last value so nothing stale looks valid
    task automatic send(input logic [7:0] kk, input logic [47:0] p, input logic [47:0] d);
        @(posedge clk);
        fe <= 1'b1;
        k <= kk;
        pw <= p;
        da <= d;
        @(posedge clk);
        fe <= 1'b0;
        k <= ~kk;
        pw <= ~p;
        da <= ~d;
    endtask
endmodule

/* File: tb_top.sv */
// testbench: bus and frame stimulus with queued expectations for the wake block
module tb_top
    import wol_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [10:0] AVS_ADDRESS = 11'h000;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0] AVS_BYTEENABLE = 4'hf;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST, WAKE_OUT, DEST_MATCH, CRC_CHECK_EN, STAMP_IND_EN, fe;
    logic lvl = 1'b0;
    logic [7:0] kind;
    logic [47:0] pw, da, rpw, rda;
    logic [31:0] rq[$];
    int wq[$];
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int wl = 0;
    int kb[3] = '{B_UCAST, B_PATTERN, B_MAGIC};
    wol_rx_wake i_dut (.*, .RX_FRAME_END(fe), .RX_UNICAST(kind[4]), .RX_BROADCAST(kind[2]),
        .RX_PATTERN_HIT(kind[1]), .RX_MAGIC(kind[0]), .RX_MAGIC_PASSWORD(rpw),
        .RX_DEST_ADDR(rda), .RX_CRC_BAD(kind[6]), .RX_SFD_BAD(kind[7]));
    wol_station i_sta (.clk(CLK), .fe(fe), .k(kind), .pw(rpw), .da(rda));
    initial begin
        forever #12.5 CLK = ~CLK;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [10:0] a, input logic [15:0] d);
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {16'h0000, d};
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    // the mask selects which status bits matter; upper half must always read zero
    task automatic rd(input logic [10:0] a, input logic [15:0] exp, input logic [15:0] m);
        rq.push_back({m, exp});
        bus(1'b0, a, 16'h0000);
    endtask
    task automatic frame(input logic [7:0] k, input logic [47:0] p, input logic [47:0] d,
        input int w);
        if (w > 0) wq.push_back(w);
        i_sta.send(k, p, d);
        repeat (30) @(posedge CLK);
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (AVS_READ && AVS_WAITREQUEST === 1'b0) begin
            chk(AVS_READDATA & {16'hffff, rq[0][31:16]}, {16'h0000, rq[0][15:0]}, "readdata");
            void'(rq.pop_front());
        end
        if (WAKE_OUT === 1'b1) wl++;
        else if (wl > 0) begin
            if (!lvl) chk(wl, wq.pop_front(), "pulse_len");
            wl = 0;
        end
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        void'($urandom(81));
        pw = 48'({$urandom(), $urandom()});
        da = 48'({$urandom(), $urandom()});
        repeat (6) @(posedge CLK);
        NRST <= 1'b1;
        rd(11'h4d0, CONFIG_RESET, 16'hffff);
        rd(11'h7fc, 16'h0000, 16'hffff);
        frame(8'h04, pw, da, 0);
        rd(11'h4d4, 16'h0000, 16'hffff);
        for (int w = 0; w < 4; w++) begin
            bus(1'b1, 11'h4d0, 16'h0084 | 16'(w << B_WIDTH_LO));
            #1 chk({STAMP_IND_EN, CRC_CHECK_EN}, 2'b11, "enh_out");
            frame(8'h04, pw, da, ((PULSE_W0 << w) * CLK_MHZ + OUT_CLK_MHZ - 1) / OUT_CLK_MHZ);
            rd(11'h4d4, 16'h0004, 16'hffff);
            rd(11'h4d4, 16'h0000, 16'hffff);
        end
        foreach (kb[i]) begin
            bus(1'b1, 11'h4d0, 16'h0080);
            frame(8'(1 << kb[i]), pw, da, 0);
            rd(11'h4d4, 16'h0000, 16'h0000);
            bus(1'b1, 11'h4d0, 16'h0080 | 16'(1 << kb[i]));
            frame(8'(1 << kb[i]), pw, da, 3);
            rd(11'h4d4, 16'(1 << kb[i]), 16'(1 << kb[i]));
        end
        for (int i = 6; i < 8; i++) begin
            frame(8'(1 << i), pw, da, 0);
            rd(11'h4d4, 16'(1 << i), 16'(1 << i));
        end
        for (int i = 0; i < 3; i++) bus(1'b1, 11'h4e4 + 11'(4 * i), pw[16 * i +: 16]);
        for (int i = 0; i < 3; i++) rd(11'h4e4 + 11'(4 * i), pw[16 * i +: 16], 16'hffff);
        bus(1'b1, 11'h4d0, 16'h00a1);
        frame(8'h01, ~pw, da, 0);
        rd(11'h4d4, 16'h0020, 16'h0020);
        frame(8'h01, pw, da, 3);
        rd(11'h4d4, 16'h0001, 16'h0021);
        for (int i = 0; i < 3; i++) bus(1'b1, 11'h4d8 + 11'(4 * i), da[16 * i +: 16]);
        for (int i = 0; i < 3; i++) rd(11'h4d8 + 11'(4 * i), da[16 * i +: 16], 16'hffff);
        frame(8'h00, pw, da, 0);
        chk(DEST_MATCH, 1'b1, "dest_match");
        frame(8'h00, pw, ~da, 0);
        chk(DEST_MATCH, 1'b0, "dest_miss");
        bus(1'b1, 11'h4d4, 16'hffff);
        rd(11'h4d4, 16'h0000, 16'hffff);
        lvl = 1'b1;
        bus(1'b1, 11'h4d0, 16'h0184);
        frame(8'h04, pw, da, 0);
        frame(8'h04, pw, da, 0);
        chk(WAKE_OUT, 1'b1, "level_hold");
        bus(1'b1, 11'h4d0, 16'h0984);
        repeat (4) @(posedge CLK);
        chk(WAKE_OUT, 1'b0, "level_clear");
        rd(11'h4d0, 16'h0184, 16'hffff);
        chk(wq.size(), 0, "pulses_left");
        test_done();
    end
endmodule
